// ==== dv/debug_probe_model.sv ====
`timescale 1ns/100ps
module debug_probe_model (
  input  wire logic        hclk,
  input  wire logic        go,
  input  wire logic [15:0] word,
  output logic             tck,
  output logic             tms,
  output logic             tdi,
  output logic             busy
);
  // Clock stands low between frames, select line idles high
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    busy = 1'b0;
  end

  // Each clock phase lasts two system cycles
  task automatic bit_out(input logic b);
    tms <= b;
    tdi <= ~tdi;
    repeat (2) @(posedge hclk);
    tck <= 1'b1;
    repeat (2) @(posedge hclk);
    tck <= 1'b0;
  endtask

  always @(posedge hclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      repeat (52) bit_out(1'b1);
      for (int i = 0; i < 16; i++) bit_out(word[i]);
      tms <= 1'b1;
      repeat (2) @(posedge hclk);
      busy <= 1'b0;
    end
  end
endmodule

// ==== dv/system_io_pin_select_tb.sv ====
`timescale 1ns/100ps
module system_io_pin_select_tb
  import sysio_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, go, busy, sw_exp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, core_debug_en;
  logic [2:0]  hsize;
  logic [4:0]  pin_out, pin_oe, port_out, port_oe, port_in, sel;
  wire  [4:0]  pin_in;
  logic [19:0] pad_cfg;
  logic        dbg_tdo, dbg_tdo_oe, dbg_swdio_out, dbg_swdio_oe, async_trace_out;
  logic        async_trace_en, dbg_tdi, dbg_tms_swdio, dbg_tck, flash_erase_req;
  logic        serial_wire_active, boundary_scan_select, test_mode_in, boundary_scan_en;
  logic        fast_flash_prog_mode, p_tck, p_tms, p_tdi, dout_lvl, erase_lvl;
  logic [15:0] word;
  int          err_count, num_checks;
  logic [4:0]  case_sel [5] = '{5'h08, 5'h00, 5'h00, 5'h00, 5'h00};
  logic [15:0] case_word [5] = '{SEQ_TO_SERIAL, 16'h1234, SEQ_TO_SERIAL, 16'hE79C,
                                 SEQ_TO_FOUR_WIRE};
  logic        case_sw [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  assign pin_in = {erase_lvl, p_tck, p_tms, dout_lvl, p_tdi};
  system_io_pin_select DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .pin_in, .pin_out, .pin_oe, .port_out, .port_oe, .port_in,
    .pad_cfg, .dbg_tdo, .dbg_tdo_oe, .dbg_swdio_out, .dbg_swdio_oe, .async_trace_out,
    .async_trace_en, .dbg_tdi, .dbg_tms_swdio, .dbg_tck, .flash_erase_req,
    .serial_wire_active, .core_debug_en, .boundary_scan_select, .test_mode_in,
    .boundary_scan_en, .fast_flash_prog_mode);
  debug_probe_model probe (.hclk, .go, .word, .tck(p_tck), .tms(p_tms), .tdi(p_tdi), .busy);

  always #12.5 hclk = ~hclk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
  endtask

  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
    chk(32'(hresp), 32'h0);
  endtask

  function automatic logic [4:0] mux(input logic [4:0] s, sys, prt);
    return (sys & ~s) | (prt & s);
  endfunction

  task automatic check_pins();
    logic [4:0] oe, o;
    logic [2:0] dbg;
    oe = mux(sel, {2'b00, sw_exp & dbg_swdio_oe, sw_exp ? async_trace_en : dbg_tdo_oe, 1'b0},
             port_oe);
    o = mux(sel, {2'b00, dbg_swdio_out, sw_exp ? async_trace_out : dbg_tdo, 1'b0}, port_out);
    dbg = {pin_in[3] & ~sel[3], pin_in[2] | sel[2], pin_in[0] | sel[0]};
    chk(32'(pin_oe), 32'(oe));
    chk(32'(pin_out & oe), 32'(o & oe));
    chk(32'(port_in), 32'(pin_in));
    chk(32'({dbg_tck, dbg_tms_swdio, dbg_tdi}), 32'(dbg));
    chk(32'(flash_erase_req), 32'(pin_in[4] & ~sel[4]));
    chk(32'(core_debug_en), 32'({2{~sel[3]}}));
  endtask

  task automatic mix(input int n);
    logic [19:0] pad;
    repeat (n) begin
      sel = 5'($urandom);
      pad = 20'($urandom);
      {port_out, port_oe, dbg_tdo, dbg_tdo_oe, dbg_swdio_out, dbg_swdio_oe, async_trace_out,
       async_trace_en, dout_lvl, erase_lvl} <= 18'($urandom);
      ahb(1'b1, SYSIO_SEL_OFFSET, 32'(sel), rd);
      ahb(1'b1, PAD_CFG_OFFSET, 32'(pad), rd);
      ahb(1'b0, SYSIO_SEL_OFFSET, 32'h0, rd);
      chk(rd, 32'(sel));
      ahb(1'b0, PAD_CFG_OFFSET, 32'h0, rd);
      chk(rd, 32'(pad));
      repeat (2) @(posedge hclk);
      chk(32'(pad_cfg), 32'(pad));
      check_pins();
    end
  endtask

  task automatic send(input logic [15:0] w);
    int n;
    word <= w;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (busy !== 1'b0 && n < 1000);
    if (busy !== 1'b0) begin
      err_count++;
      tally_and_finish();
    end
    repeat (2) @(posedge hclk);
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, haddr, htrans, hwrite, hsize, hwdata, go, word, sel, sw_exp} = '0;
    {port_out, port_oe, dbg_tdo, dbg_tdo_oe, dbg_swdio_out, dbg_swdio_oe} = '0;
    {async_trace_out, async_trace_en, dout_lvl, erase_lvl, boundary_scan_select} = '0;
    test_mode_in = 1'b1;
    err_count = 0;
    num_checks = 0;
    void'($urandom(27506));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, SYSIO_SEL_OFFSET, 32'h0, rd);
    chk(rd, 32'(SYSIO_SEL_RESET));
    ahb(1'b0, STATUS_OFFSET, 32'h0, rd);
    chk(rd, 32'h0000000A);
    chk(32'(fast_flash_prog_mode), 32'h1);
    ahb(1'b0, 12'h00C, 32'h0, rd);
    chk(rd, 32'h0);
    check_pins();
    boundary_scan_select <= 1'b1;
    ahb(1'b0, STATUS_OFFSET, 32'h0, rd);
    chk(32'(rd[2]), 32'h1);
    chk(32'(boundary_scan_en), 32'h1);
    boundary_scan_select <= 1'b0;
    mix(12);
    for (int i = 0; i < 5; i++) begin
      sel = case_sel[i];
      ahb(1'b1, SYSIO_SEL_OFFSET, 32'(sel), rd);
      send(case_word[i]);
      sw_exp = case_sw[i];
      chk(32'(serial_wire_active), 32'(sw_exp));
      mix(6);
    end
    tally_and_finish();
  end
endmodule

// ==== rtl/debug_port_switch.sv ====
`timescale 1ns/100ps
module debug_port_switch
  import sysio_pkg::*;
(
  input wire logic       hclk,
  input wire logic       hresetn,
  debug_switch_if.det    sw
);
  logic          tck_prev_reg;
  logic [5:0]    ones_reg;
  logic [4:0]    bits_reg;
  logic [15:0]   shift_reg;
  logic          serial_reg;
  switch_state_t state_reg;
  logic          tck_rise;
  logic [15:0]   shift_next;

  assign tck_rise   = sw.tck && !tck_prev_reg;
  assign shift_next = {sw.tms, shift_reg[15:1]};
  assign sw.serial_wire_active = serial_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tck_prev_reg <= 1'b0;
    end else begin
      tck_prev_reg <= sw.tck;
    end
  end

  // Line reset of at least 50 ones, then a 16-bit select word, LSB first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg  <= SW_COUNT;
      ones_reg   <= 6'h00;
      bits_reg   <= 5'h00;
      shift_reg  <= 16'h0000;
      serial_reg <= 1'b0;
    end else if (tck_rise) begin
      case (state_reg)
        SW_COUNT: begin
          if (sw.tms) begin
            if (ones_reg < 6'(LINE_RESET_ONES)) begin
              ones_reg <= ones_reg + 6'h01;
            end
          end else if (ones_reg == 6'(LINE_RESET_ONES)) begin
            state_reg <= SW_CAPTURE;
            shift_reg <= shift_next;
            bits_reg  <= 5'h01;
          end else begin
            ones_reg <= 6'h00;
          end
        end
        SW_CAPTURE: begin
          shift_reg <= shift_next;
          bits_reg  <= bits_reg + 5'h01;
          if (bits_reg == 5'(SEQ_BITS - 1)) begin
            state_reg <= SW_COUNT;
            ones_reg  <= sw.tms ? 6'h01 : 6'h00;
            if (shift_next == SEQ_TO_SERIAL) begin
              serial_reg <= 1'b1;
            end else if (shift_next == SEQ_TO_FOUR_WIRE) begin
              serial_reg <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= SW_COUNT;
        end
      endcase
    end
  end

  a_switch_needs_seq: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(serial_reg) |-> $past(state_reg) == SW_CAPTURE)
    else $error("serial wire enabled without select word");
endmodule

// ==== rtl/debug_switch_if.sv ====
`timescale 1ns/100ps
interface debug_switch_if;
  logic tck;
  logic tms;
  logic serial_wire_active;

  modport ctrl (output tck, output tms, input serial_wire_active);
  modport det  (input tck, input tms, output serial_wire_active);
endinterface

// ==== rtl/sysio_pkg.sv ====
package sysio_pkg;
  localparam int          NUM_PINS         = 5;
  localparam int          PAD_BITS         = 4;
  // Register byte offsets
  localparam logic [11:0] SYSIO_SEL_OFFSET = 12'h000;
  localparam logic [11:0] PAD_CFG_OFFSET   = 12'h004;
  localparam logic [11:0] STATUS_OFFSET    = 12'h008;
  // Selection bit positions
  localparam int          PIN_DATA_IN      = 0;
  localparam int          PIN_DATA_OUT     = 1;
  localparam int          PIN_MODE_SEL     = 2;
  localparam int          PIN_TEST_CLK     = 3;
  localparam int          PIN_ERASE        = 4;
  // Status bit positions
  localparam int          ST_SERIAL_WIRE   = 0;
  localparam int          ST_TEST_LATCHED  = 1;
  localparam int          ST_BSCAN         = 2;
  localparam int          ST_FAST_FLASH    = 3;
  // Reset values
  localparam logic [4:0]  SYSIO_SEL_RESET  = 5'h00;
  localparam logic [19:0] PAD_CFG_RESET    = 20'h00000;
  // Debug port switching sequence
  localparam int          LINE_RESET_ONES  = 50;
  localparam int          SEQ_BITS         = 16;
  localparam logic [15:0] SEQ_TO_SERIAL    = 16'hE79E;
  localparam logic [15:0] SEQ_TO_FOUR_WIRE = 16'hE73C;

  typedef enum logic [1:0] {
    SW_COUNT,
    SW_CAPTURE
  } switch_state_t;
endpackage

// ==== rtl/system_io_pin_select.sv ====
// Functional notes
// - Shared pins come up in system/debug function until software selects port.
// - One selection bit per pin: data-in, data-out, mode-select, clock, erase.
// - Debug/port mode switching only through bus-matrix special registers.
// - Pad pull-up, trigger, debounce, filter settings writable in either mode.
// - Boundary-scan select high routes test port to boundary scan.
// - Four-wire debug port active from reset; serial wire off until switched.
// - Trace output on data-out pin only while serial wire port active.
// - One debug pin set gives access to both processor cores.
// - Test input latched at start-up selects fast flash programming while boundary-scan select is low; boundary scan follows boundary-scan select.
`timescale 1ns/100ps
module system_io_pin_select
  import sysio_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [4:0]  pin_in,
  output logic [4:0]       pin_out,
  output logic [4:0]       pin_oe,
  input  wire logic [4:0]  port_out,
  input  wire logic [4:0]  port_oe,
  output logic [4:0]       port_in,
  output logic [19:0]      pad_cfg,
  input  wire logic        dbg_tdo,
  input  wire logic        dbg_tdo_oe,
  input  wire logic        dbg_swdio_out,
  input  wire logic        dbg_swdio_oe,
  input  wire logic        async_trace_out,
  input  wire logic        async_trace_en,
  output logic             dbg_tdi,
  output logic             dbg_tms_swdio,
  output logic             dbg_tck,
  output logic             flash_erase_req,
  output logic             serial_wire_active,
  output logic [1:0]       core_debug_en,
  input  wire logic        boundary_scan_select,
  input  wire logic        test_mode_in,
  output logic             boundary_scan_en,
  output logic             fast_flash_prog_mode
);
  logic [4:0]  sysio_sel_reg;
  logic [19:0] pad_cfg_reg;
  logic        wr_pend_reg;
  logic [11:0] addr_reg;
  logic        test_latched_reg;
  logic        test_captured_reg;
  logic        addr_phase;
  logic [4:0]  sys_out;
  logic [4:0]  sys_oe;

  debug_switch_if sw_if ();

  debug_port_switch u_switch (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sw      (sw_if.det)
  );

  function automatic logic [31:0] read_word(input logic [11:0] a);
    case (a)
      SYSIO_SEL_OFFSET: read_word = {27'h0000000, sysio_sel_reg};
      PAD_CFG_OFFSET:   read_word = {12'h000, pad_cfg_reg};
      STATUS_OFFSET:    read_word = {28'h0000000, fast_flash_prog_mode,
                                     boundary_scan_en, test_latched_reg,
                                     serial_wire_active};
      default:          read_word = 32'h00000000;
    endcase
  endfunction

  // Zero-wait slave, always OKAY
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_phase = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 12'h000;
      hrdata      <= 32'h00000000;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase) begin
        addr_reg <= {haddr[11:2], 2'b00};
      end
      hrdata <= (addr_phase && !hwrite) ? read_word({haddr[11:2], 2'b00}) : 32'h00000000;
    end
  end

  // Mode selection reachable only from the register bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysio_sel_reg <= SYSIO_SEL_RESET;
    end else if (wr_pend_reg && addr_reg == SYSIO_SEL_OFFSET) begin
      sysio_sel_reg <= hwdata[4:0];
    end
  end

  // Pad settings stay writable whatever the selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_cfg_reg <= PAD_CFG_RESET;
    end else if (wr_pend_reg && addr_reg == PAD_CFG_OFFSET) begin
      pad_cfg_reg <= hwdata[19:0];
    end
  end
  assign pad_cfg = pad_cfg_reg;

  // Test input is caught on the first edge after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      test_captured_reg <= 1'b0;
      test_latched_reg  <= 1'b0;
    end else if (!test_captured_reg) begin
      test_captured_reg <= 1'b1;
      test_latched_reg  <= test_mode_in;
    end
  end

  assign boundary_scan_en     = boundary_scan_select;
  assign fast_flash_prog_mode = test_latched_reg && !boundary_scan_select;

  // Debug inputs idle when the pin belongs to the port controller
  assign sw_if.tck       = sysio_sel_reg[PIN_TEST_CLK] ? 1'b0 : pin_in[PIN_TEST_CLK];
  assign sw_if.tms       = sysio_sel_reg[PIN_MODE_SEL] ? 1'b1 : pin_in[PIN_MODE_SEL];
  assign dbg_tck         = sw_if.tck;
  assign dbg_tms_swdio   = sw_if.tms;
  assign dbg_tdi         = sysio_sel_reg[PIN_DATA_IN] ? 1'b1 : pin_in[PIN_DATA_IN];
  assign flash_erase_req = !sysio_sel_reg[PIN_ERASE] && pin_in[PIN_ERASE];
  assign port_in         = pin_in;
  assign serial_wire_active = sw_if.serial_wire_active;
  assign core_debug_en   = {2{!sysio_sel_reg[PIN_TEST_CLK]}};

  always_comb begin
    sys_out = 5'h00;
    sys_oe  = 5'h00;
    if (serial_wire_active) begin
      sys_out[PIN_DATA_OUT] = async_trace_out;
      sys_oe[PIN_DATA_OUT]  = async_trace_en;
      sys_out[PIN_MODE_SEL] = dbg_swdio_out;
      sys_oe[PIN_MODE_SEL]  = dbg_swdio_oe;
    end else begin
      sys_out[PIN_DATA_OUT] = dbg_tdo;
      sys_oe[PIN_DATA_OUT]  = dbg_tdo_oe;
    end
  end

  // Each pin picks port or system drive on its own selection bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= 5'h00;
      pin_oe  <= 5'h00;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        pin_out[i] <= sysio_sel_reg[i] ? port_out[i] : sys_out[i];
        pin_oe[i]  <= sysio_sel_reg[i] ? port_oe[i] : sys_oe[i];
      end
    end
  end

  a_sel_write_takes: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_phase && hwrite && haddr[11:0] == SYSIO_SEL_OFFSET ##1 1'b1
    |=> sysio_sel_reg == $past(hwdata[4:0]))
    else $error("selection write not stored");

  a_sel_only_by_bus: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_pend_reg && addr_reg == SYSIO_SEL_OFFSET) |=> $stable(sysio_sel_reg))
    else $error("selection changed without bus write");

  a_pad_write_takes: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_reg && addr_reg == PAD_CFG_OFFSET |=> pad_cfg == $past(hwdata[19:0]))
    else $error("pad settings write lost");

  a_trace_not_jtag: assert property (@(posedge hclk) disable iff (!hresetn)
    !serial_wire_active && !sysio_sel_reg[PIN_DATA_OUT]
    |=> pin_oe[PIN_DATA_OUT] == $past(dbg_tdo_oe))
    else $error("trace driven in four-wire mode");

  a_trace_in_serial: assert property (@(posedge hclk) disable iff (!hresetn)
    serial_wire_active && !sysio_sel_reg[PIN_DATA_OUT]
    |=> pin_oe[PIN_DATA_OUT] == $past(async_trace_en)
    && pin_out[PIN_DATA_OUT] == $past(async_trace_out))
    else $error("trace missing on data-out pin in serial wire mode");

  // Erase request drops in the same cycle as the selection bit rises
  a_port_owns_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    sysio_sel_reg[PIN_ERASE] |-> !flash_erase_req
    ##1 pin_oe[PIN_ERASE] == $past(port_oe[PIN_ERASE]))
    else $error("port pin not handed over");

  a_port_data_out: assert property (@(posedge hclk) disable iff (!hresetn)
    sysio_sel_reg[PIN_DATA_OUT] |=> pin_out[PIN_DATA_OUT] == $past(port_out[PIN_DATA_OUT])
    && pin_oe[PIN_DATA_OUT] == $past(port_oe[PIN_DATA_OUT]))
    else $error("data-out pin not driven by port controller");

  a_system_default: assert property (@(posedge hclk)
    $rose(hresetn) |-> sysio_sel_reg == 5'h00 && !serial_wire_active)
    else $error("pins not in system function after reset");

  a_bscan_route: assert property (@(posedge hclk) disable iff (!hresetn)
    boundary_scan_select |-> boundary_scan_en && !fast_flash_prog_mode)
    else $error("boundary scan not routed");

  a_test_latched: assert property (@(posedge hclk) disable iff (!hresetn)
    test_captured_reg |=> $stable(test_latched_reg))
    else $error("test mode changed after start-up");

  a_both_cores: assert property (@(posedge hclk) disable iff (!hresetn)
    core_debug_en[0] == core_debug_en[1])
    else $error("cores see different debug access");

  c_serial_switch: cover property (@(posedge hclk) $rose(serial_wire_active));
  c_pad_write:     cover property (@(posedge hclk) wr_pend_reg && addr_reg == PAD_CFG_OFFSET);
  c_port_handover: cover property (@(posedge hclk) $rose(sysio_sel_reg[PIN_DATA_OUT]));
  c_status_read:   cover property (@(posedge hclk)
    addr_phase && !hwrite && haddr[11:0] == STATUS_OFFSET);
endmodule
